//--- spg_pkg.sv
package spg_pkg;

  // ************************************************************
  // Register map (word offsets are byte addresses)
  // ************************************************************
  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  DURATION_OFFSET = 8'h04;
  localparam logic [7:0]  DELAY_OFFSET    = 8'h08;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h0C;

  // ************************************************************
  // Field layout of the control register
  // ************************************************************
  localparam int          CTRL_MODE_LSB   = 0;
  localparam int          CTRL_INV_BIT    = 2;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [1:0]  MODE_RESET      = 2'h0;
  localparam logic        INV_RESET       = 1'b0;
  localparam logic [16:0] DURATION_RESET  = 17'h00064;
  localparam logic [16:0] DELAY_RESET     = 17'h00000;

  // ************************************************************
  // Timing: settings are in units of 0.01 us (10 ns)
  // ************************************************************
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          TICK_NS         = 10;
  localparam int          TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [16:0] DURATION_MIN    = 17'h00064;
  localparam logic [16:0] DURATION_MAX    = 17'h186A0;
  localparam logic [16:0] DELAY_MAX       = 17'h186A0;
  localparam int          CNT_W           = 17;

  typedef enum logic [1:0] {
    SPG_MODE_OFF   = 2'h0,
    SPG_MODE_TIMED = 2'h1,
    SPG_MODE_WIDTH = 2'h2,
    SPG_MODE_ON    = 2'h3
  } spg_mode_type;

endpackage : spg_pkg

//--- spg_delay_if.sv
`timescale 1ns/100ps
interface spg_delay_if;
  import spg_pkg::*;
  logic             tick;
  logic [CNT_W-1:0] delay;
  logic             level_in;
  logic             level_out;
  modport line (input tick, input delay, input level_in, output level_out);
  modport ctrl (output tick, output delay, output level_in, input level_out);
endinterface : spg_delay_if

//--- spg_delay_line.sv
`timescale 1ns/100ps
// Delays a level by a programmed number of ticks, edge by edge.
// Holds up to EDGES pending edges; a pulse shorter than the delay is
// kept exactly, but edges beyond the queue depth are dropped.
module spg_delay_line
  import spg_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control side
  spg_delay_if.line dl
);

  localparam int EDGES = 8;

  logic [CNT_W-1:0] due_r [EDGES];
  logic [EDGES-1:0] busy_r;
  logic             last_r;
  logic             out_r;
  logic [2:0]       wr_r;
  logic [2:0]       rd_r;

  assign dl.level_out = out_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_r <= 1'b0;
    end else begin
      last_r <= dl.level_in;
    end
  end

  // Zero delay bypasses the queue
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_r  <= 1'b0;
      wr_r   <= 3'h0;
      rd_r   <= 3'h0;
      busy_r <= '0;
    end else if (dl.delay == '0) begin
      out_r  <= dl.level_in;
      busy_r <= '0;
      wr_r   <= 3'h0;
      rd_r   <= 3'h0;
    end else begin
      if (busy_r[rd_r] && dl.tick && due_r[rd_r] <= 17'h00001) begin
        out_r         <= ~out_r;
        busy_r[rd_r]  <= 1'b0;
        rd_r          <= rd_r + 3'h1;
      end
      if (dl.level_in != last_r && !busy_r[wr_r]) begin
        busy_r[wr_r] <= 1'b1;
        wr_r         <= wr_r + 3'h1;
      end
    end
  end

  for (genvar g = 0; g < EDGES; g++) begin : g_slot
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        due_r[g] <= '0;
      end else if (dl.level_in != last_r && !busy_r[g] && wr_r == 3'(g)) begin
        due_r[g] <= dl.delay;
      end else if (busy_r[g] && dl.tick && due_r[g] != '0) begin
        due_r[g] <= due_r[g] - 17'h00001;
      end
    end
  end

endmodule : spg_delay_line

//--- spg_strobe.sv
`timescale 1ns/100ps
module spg_strobe
  import spg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Line trigger: external pin, or internal free-run line start
  input  wire logic        trig_pin_i,
  input  wire logic        line_start_i,
  input  wire logic        free_run_i,
  // Strobe output
  output logic             strobe_o
);

  // ************************************************************
  // Register file
  // ************************************************************
  spg_mode_type     mode_r;
  logic             inv_r;
  logic [CNT_W-1:0] dur_r;
  logic [CNT_W-1:0] dly_r;
  logic             trig_s1_r;
  logic             trig_s2_r;
  logic             trig_d_r;
  logic             pulse_r;
  logic [CNT_W-1:0] left_r;
  logic             out_r;
  logic [CNT_W-1:0] wdat;
  logic             wr_en;

  assign wr_en = cyc_i && stb_i && we_i && !ack_o;
  assign wdat  = dat_i[CNT_W-1:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Control bits: byte lane 0 only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= spg_mode_type'(MODE_RESET);
      inv_r  <= INV_RESET;
    end else if (wr_en && adr_i == CTRL_OFFSET && sel_i[0]) begin
      mode_r <= spg_mode_type'(dat_i[CTRL_MODE_LSB +: 2]);
      inv_r  <= dat_i[CTRL_INV_BIT];
    end
  end

  // Out-of-range writes are clamped, so the pulse always stays legal.
  // The full bus word is compared, so large values cannot wrap into range.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dur_r <= DURATION_RESET;
      dly_r <= DELAY_RESET;
    end else if (wr_en && sel_i == 4'hF) begin
      if (adr_i == DURATION_OFFSET) begin
        dur_r <= (dat_i < 32'(DURATION_MIN)) ? DURATION_MIN :
                 (dat_i > 32'(DURATION_MAX)) ? DURATION_MAX : wdat;
      end
      if (adr_i == DELAY_OFFSET) begin
        dly_r <= (dat_i > 32'(DELAY_MAX)) ? DELAY_MAX : wdat;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      unique case (adr_i)
        CTRL_OFFSET:     dat_o <= {29'h0, inv_r, mode_r};
        DURATION_OFFSET: dat_o <= {15'h0, dur_r};
        DELAY_OFFSET:    dat_o <= {15'h0, dly_r};
        STATUS_OFFSET:   dat_o <= {29'h0, strobe_o, pulse_r, trig_d_r};
        default:         dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Trigger source
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
    end else begin
      trig_s1_r <= trig_pin_i;
      trig_s2_r <= trig_s1_r;
    end
  end

  logic trig_lvl;
  logic trig_rise;
  assign trig_lvl  = free_run_i ? line_start_i : trig_s2_r;
  assign trig_rise = trig_lvl && !trig_d_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_d_r <= 1'b0;
    end else begin
      trig_d_r <= trig_lvl;
    end
  end

  // ************************************************************
  // 0.01 us tick and timed pulse
  // ************************************************************
  logic tick;
  if (TICK_CYCLES > 1) begin : g_div
    logic [7:0] div_r;
    always_ff @(posedge clk_i) begin
      if (rst_i || div_r == 8'(TICK_CYCLES - 1)) begin
        div_r <= 8'h00;
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
    assign tick = (div_r == 8'(TICK_CYCLES - 1));
  end else begin : g_nodiv
    assign tick = 1'b1;
  end

  // A trigger during a running pulse restarts it
  always_ff @(posedge clk_i) begin
    if (rst_i || mode_r != SPG_MODE_TIMED) begin
      pulse_r <= 1'b0;
      left_r  <= '0;
    end else if (trig_rise) begin
      pulse_r <= 1'b1;
      left_r  <= dur_r;
    end else if (pulse_r && tick) begin
      if (left_r <= 17'h00001) begin
        pulse_r <= 1'b0;
      end
      left_r <= left_r - 17'h00001;
    end
  end

  // ************************************************************
  // Mode select, delay, inversion
  // ************************************************************
  logic sel_lvl;
  always_comb begin
    unique case (mode_r)
      SPG_MODE_OFF:   sel_lvl = 1'b0;
      SPG_MODE_TIMED: sel_lvl = pulse_r;
      SPG_MODE_WIDTH: sel_lvl = trig_lvl;
      SPG_MODE_ON:    sel_lvl = 1'b1;
    endcase
  end

  spg_delay_if dif ();
  assign dif.tick     = tick;
  assign dif.delay    = dly_r;
  assign dif.level_in = sel_lvl;

  spg_delay_line u_delay (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .dl    (dif.line)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_r <= 1'b0;
    end else begin
      out_r <= dif.level_out ^ inv_r;
    end
  end

  assign strobe_o = out_r;

endmodule : spg_strobe

//--- spg_strobe_asserts.sv
`timescale 1ns/100ps
module spg_strobe_asserts
  import spg_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // Trigger and strobe
  input wire logic        free_run_i,
  input wire logic        line_start_i,
  input wire logic        strobe_o
);
  logic [1:0]  md_r;
  logic        inv_r;
  logic [16:0] dur_r;
  logic [16:0] dly_r;
  logic [17:0] cnt_r;
  logic [17:0] age_r;
  logic [17:0] hi_r;
  logic [5:0]  ls_r;
  wire         wr = cyc_i && stb_i && we_i && ack_o;
  function automatic logic [16:0] clip(input logic [31:0] v, input logic [16:0] lo);
    clip = (v < {15'h0, lo}) ? lo : ((v > {15'h0, DURATION_MAX}) ? DURATION_MAX : v[16:0]);
  endfunction : clip
  always_ff @(posedge clk_i) begin
    ls_r  <= {ls_r[4:0], line_start_i};
    cnt_r <= (rst_i || wr) ? 18'h0 : cnt_r + {17'h0, !cnt_r[17]};
    age_r <= (line_start_i && !ls_r[0]) ? 18'h0 : age_r + {17'h0, !age_r[17]};
    hi_r  <= (strobe_o != inv_r) ? hi_r + 18'h1 : 18'h0;
  end
  // Shadow of the settings, taken one edge after the write lands, while ack_o is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      md_r  <= MODE_RESET;
      inv_r <= INV_RESET;
      dur_r <= DURATION_RESET;
      dly_r <= DELAY_RESET;
    end else if (wr && adr_i == CTRL_OFFSET && sel_i[0]) begin
      md_r  <= dat_i[1:0];
      inv_r <= dat_i[2];
    end else if (wr && sel_i == 4'hF && adr_i == DURATION_OFFSET) begin
      dur_r <= clip(dat_i, DURATION_MIN);
    end else if (wr && sel_i == 4'hF && adr_i == DELAY_OFFSET) begin
      dly_r <= clip(dat_i, 17'h00000);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_quiet: assert property ($fell(rst_i) |-> !strobe_o && !ack_o)
    else $error("outputs not idle after reset");
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged next cycle");
  a_ack_once: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  a_off_idle: assert property (md_r == 2'h0 && cnt_r > dly_r + 8 |-> strobe_o == inv_r)
    else $error("strobe active while off");
  a_on_level: assert property (md_r == 2'h3 && cnt_r > dly_r + 8 |-> strobe_o != inv_r)
    else $error("strobe not held in on mode");
  a_timed_width: assert property (md_r == 2'h1 && cnt_r > dly_r + 8 && hi_r != 0
    && strobe_o == inv_r |-> hi_r + 1 >= dur_r && hi_r <= dur_r + 2)
    else $error("timed pulse width wrong");
  a_width_follow: assert property (md_r == 2'h2 && dly_r == 0 && cnt_r > 8 && free_run_i
    && (ls_r == 6'h3F || ls_r == 6'h00) |-> strobe_o == (ls_r[0] ^ inv_r))
    else $error("strobe does not follow trigger");
  a_delay_span: assert property (md_r == 2'h2 && free_run_i && cnt_r > dly_r + 8 && hi_r == 0
    && strobe_o != inv_r |-> age_r >= dly_r && age_r <= dly_r + 5)
    else $error("strobe delay out of range");
  c_timed: cover property (md_r == 2'h1 && hi_r != 0 && strobe_o == inv_r);
  c_delay: cover property (dly_r != 0 && md_r == 2'h2 && strobe_o != inv_r);
  c_inv_on: cover property (inv_r && md_r == 2'h3 && !strobe_o);
endmodule : spg_strobe_asserts
bind spg_strobe spg_strobe_asserts spg_strobe_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .ack_o(ack_o), .free_run_i(free_run_i), .line_start_i(line_start_i), .strobe_o(strobe_o));

//--- spg_trig_src.sv
`timescale 1ns/100ps
module spg_trig_src (
  // Clock and command
  input  wire logic        clk_i,
  input  wire logic        fire_i,
  input  wire logic [15:0] hi_i,
  // Line trigger toward the camera
  output logic             trig_o
);
  logic [15:0] left_r = 16'h0;
  // One line trigger per fire, hi_i cycles long; idles low between lines
  always_ff @(posedge clk_i) begin
    left_r <= fire_i ? hi_i : left_r - {15'h0, left_r != 16'h0};
  end
  assign trig_o = (left_r != 16'h0);
endmodule : spg_trig_src

//--- test_spg_strobe.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_spg_strobe;
  import spg_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic        fire = 0, fr = 1, trig, strobe_o, ack_o;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [15:0] hi = 16'h1;
  int          fail_count = 0, checks_done = 0, t, w;
  spg_strobe spg_strobe_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .trig_pin_i(trig), .line_start_i(trig), .free_run_i(fr), .strobe_o(strobe_o));
  spg_trig_src spg_trig_src_inst (.clk_i(clk_i), .fire_i(fire), .hi_i(hi), .trig_o(trig));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1;
    stb_i <= 1;
    we_i  <= wr;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    if (ack_o !== 1'b1) fail_count++;
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask : bus
  // Fires one trigger and measures lead time and active width of the strobe
  task automatic shot(input logic [15:0] h, input logic idle);
    hi   <= h;
    fire <= 1;
    @(posedge clk_i);
    fire <= 0;
    t = 0;
    w = 0;
    while (strobe_o === idle && t < 3000) begin
      @(posedge clk_i);
      t++;
    end
    while (strobe_o !== idle && w < 3000) begin
      @(posedge clk_i);
      w++;
    end
    repeat (20) @(posedge clk_i);
  endtask : shot
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    // The tests take about 4,000 cycles; two and a half times that means a hang
    #100_000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    bus(0, CTRL_OFFSET, 0);     `CHK("ctrl", 32'h0, rd)
    bus(0, DURATION_OFFSET, 0); `CHK("dur", 32'h64, rd)
    bus(0, 8'h10, 0);           `CHK("unmapped", 32'h0, rd)
    bus(0, DELAY_OFFSET, 0);    `CHK("dly", 32'h0, rd)
    shot(16'h14, 0);            `CHK("off", 3000, t)
    $display("test reset_off done");
    bus(1, CTRL_OFFSET, 3);
    repeat (10) @(posedge clk_i);
    `CHK("on", 1'b1, strobe_o)
    bus(0, STATUS_OFFSET, 0);   `CHK("status", 32'h4, rd)
    bus(1, CTRL_OFFSET, 7);
    repeat (10) @(posedge clk_i);
    `CHK("on_inv", 1'b0, strobe_o)
    $display("test on_invert done");
    bus(1, DURATION_OFFSET, 32'h32);
    bus(0, DURATION_OFFSET, 0); `CHK("dur_min", 32'h64, rd)
    bus(1, DURATION_OFFSET, 32'h30D40);
    bus(0, DURATION_OFFSET, 0); `CHK("dur_max", 32'h186A0, rd)
    sel_i <= 4'h3;
    bus(1, DURATION_OFFSET, 32'h200);
    sel_i <= 4'hF;
    bus(0, DURATION_OFFSET, 0); `CHK("dur_sel", 32'h186A0, rd)
    bus(1, DURATION_OFFSET, 32'h96);
    bus(1, CTRL_OFFSET, 1);
    shot(16'h5, 0);             `CHK("timed", 1, w >= 149 && w <= 152)
    fr <= 0;
    bus(1, CTRL_OFFSET, 5);
    shot(16'h5, 1);             `CHK("timed_inv", 1, w >= 149 && w <= 152)
    fr <= 1;
    $display("test timed done");
    bus(1, CTRL_OFFSET, 2);
    shot(16'h28, 0);            `CHK("width", 40, w)
    bus(1, DELAY_OFFSET, 32'hC8);
    repeat (250) @(posedge clk_i);
    shot(16'h28, 0);            `CHK("width_dly", 40, w)
    `CHK("delay", 1, t >= 200 && t <= 206)
    $display("test width_delay done");
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    bus(0, DELAY_OFFSET, 0);    `CHK("dly_rst", 32'h0, rd)
    `CHK("strobe_rst", 1'b0, strobe_o)
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule : test_spg_strobe
